/* hw/lre_pkg.sv */
// Package for the literal and return execution block.
// Assumes a 14-bit instruction word and 13-bit program counter.
package lre_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W   = 13;
  localparam int DATA_W = 8;
  // Opcode patterns for the executed instructions
  localparam logic [13:0] OPC_NOP     = 14'h0000;
  localparam logic [13:0] OPC_RETURN  = 14'h0008;
  localparam logic [13:0] OPC_IRQ_RET = 14'h0009;
  localparam logic [5:0]  OPC_LIT_MSK = 6'h3c; // top bits 13:10 kept
  localparam logic [5:0]  OPC_LDLIT   = 6'h30; // 11 00xx kkkk kkkk
  localparam logic [5:0]  OPC_LITRET  = 6'h34; // 11 01xx kkkk kkkk
  // Field positions
  localparam int LIT_LSB = 0;
  localparam int GIE_BIT = 7; // global_irq_enable in interrupt_control_reg
  // Reset values
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST  = 13'h0000;
  localparam logic [7:0]  ICR_RST = 8'h00;
  // Cycle counts
  localparam int CYC_ONE = 1;
  localparam int CYC_TWO = 2;
  typedef enum logic [2:0] {
    LRE_OP_NONE, LRE_OP_NOP, LRE_OP_LDLIT, LRE_OP_LITRET,
    LRE_OP_RET, LRE_OP_IRQRET
  } lre_op_t;
  typedef enum logic {LRE_ST_EXEC, LRE_ST_FLUSH} lre_state_t;
endpackage : lre_pkg

/* hw/lre_exec.sv */
// Execution unit for load-literal, no-op and the three returns.
// Assumes fetch offers one word per cycle with insn_valid, and a return
// stack whose top is readable combinationally at stack_top.
`timescale 1ns/1ps
`default_nettype none
// Masked compare of one word against a fixed opcode pattern; the
// decoder below uses one instance per executed instruction.
module lre_match
  import lre_pkg::*;
#(
  parameter int               WIDTH   = INSN_W, // Word width
  parameter logic [WIDTH-1:0] MASK    = '1,     // Bits that count
  parameter logic [WIDTH-1:0] PATTERN = '0      // Value they must hold
) (
  input  wire logic [WIDTH-1:0] word,  // Word under test
  output logic                  hit    // Pattern matched
);
  // A pattern bit outside the mask could never match, so refuse it
  if ((PATTERN & ~MASK) != '0) begin : g_bad_pattern
    $error("lre_match: pattern bits lie outside the mask");
  end

  // Cleared mask bits are don't-cares
  assign hit = ((word & MASK) == PATTERN);
endmodule // lre_match

// Executes load-literal, no-op and the three returns, one group of
// state per process pair.
module lre_exec
  import lre_pkg::*;
#(
  parameter int INSN_WIDTH = INSN_W, // Instruction word width
  parameter int PC_WIDTH   = PC_W,   // Program counter width
  parameter int DATA_WIDTH = DATA_W  // Accumulator width
) (
  input  wire logic                  mclk,        // Core clock
  input  wire logic                  sys_rst,     // Async reset, high
  input  wire logic [INSN_WIDTH-1:0] insn,        // Fetched word
  input  wire logic                  insn_valid,  // Word valid
  input  wire logic [PC_WIDTH-1:0]   stack_top,   // Top of stack
  input  wire logic                  irq_en_clr,  // Clear enable
  output logic      [DATA_WIDTH-1:0] acc,         // Accumulator
  output logic      [PC_WIDTH-1:0]   pc,          // Program counter
  output logic      [7:0]            irq_ctrl,    // Interrupt control
  output logic                       stack_pop,   // One-cycle pop
  output logic                       insn_ready,  // Low in flush
  output logic                       status_we    // Always low here
);

  lre_state_t            state;           // Sequencer state
  lre_state_t            next_state;
  lre_op_t               op;              // Decoded word
  lre_op_t               exec_op;         // Decoded word, if taken
  logic [DATA_WIDTH-1:0] next_acc;
  logic [PC_WIDTH-1:0]   next_pc;
  logic [7:0]            next_irq_ctrl;
  logic                  next_stack_pop;
  logic                  next_ready;
  logic                  next_status_we;
  logic                  hit_nop;
  logic                  hit_ret;
  logic                  hit_irqret;
  logic                  hit_ldlit;
  logic                  hit_litret;

  // The opcode table is fixed at fourteen bits with an 8-bit literal
  if (INSN_WIDTH != INSN_W) begin : g_bad_insn
    $error("lre_exec: instruction width must match the opcodes");
  end
  if (DATA_WIDTH != DATA_W) begin : g_bad_data
    $error("lre_exec: accumulator must hold the whole literal");
  end
  // Program counter wraps silently; a very wide one serves nothing
  if (PC_WIDTH < 1 || PC_WIDTH > 16) begin : g_bad_pc
    $error("lre_exec: program counter width out of range");
  end
  if (GIE_BIT > 7) begin : g_bad_gie
    $error("lre_exec: enable bit lies outside the control register");
  end

  // Exact matches for the three fixed words
  lre_match #(
    .WIDTH   (INSN_WIDTH),
    .MASK    ({INSN_WIDTH{1'b1}}),
    .PATTERN (OPC_NOP)
  ) u_hit_nop (
    .word (insn),
    .hit  (hit_nop)
  );
  lre_match #(
    .WIDTH   (INSN_WIDTH),
    .MASK    ({INSN_WIDTH{1'b1}}),
    .PATTERN (OPC_RETURN)
  ) u_hit_ret (
    .word (insn),
    .hit  (hit_ret)
  );
  lre_match #(
    .WIDTH   (INSN_WIDTH),
    .MASK    ({INSN_WIDTH{1'b1}}),
    .PATTERN (OPC_IRQ_RET)
  ) u_hit_irqret (
    .word (insn),
    .hit  (hit_irqret)
  );

  // Literal ops ignore bits 9:8, so assembled zeros are harmless
  lre_match #(
    .WIDTH   (INSN_WIDTH),
    .MASK    ({OPC_LIT_MSK, 8'h00}),
    .PATTERN ({OPC_LDLIT, 8'h00})
  ) u_hit_ldlit (
    .word (insn),
    .hit  (hit_ldlit)
  );
  lre_match #(
    .WIDTH   (INSN_WIDTH),
    .MASK    ({OPC_LIT_MSK, 8'h00}),
    .PATTERN ({OPC_LITRET, 8'h00})
  ) u_hit_litret (
    .word (insn),
    .hit  (hit_litret)
  );

  // Priority decode; a word matching nothing executes as nothing
  always_comb begin
    op = LRE_OP_NONE;
    if (insn_valid) begin
      if (hit_nop) begin
        op = LRE_OP_NOP;
      end else if (hit_ret) begin
        op = LRE_OP_RET;
      end else if (hit_irqret) begin
        op = LRE_OP_IRQRET;
      end else if (hit_ldlit) begin
        op = LRE_OP_LDLIT;
      end else if (hit_litret) begin
        op = LRE_OP_LITRET;
      end
    end
  end

  // A word offered during the flush cycle is dropped here
  always_comb begin
    exec_op = LRE_OP_NONE;
    if (state == LRE_ST_EXEC) begin
      exec_op = op;
    end
  end

  // Sequencer: returns spend a second cycle while fetch refills
  always_comb begin
    next_state = state;
    next_ready = 1'b1;
    unique case (state)
      LRE_ST_EXEC: begin
        unique case (exec_op)
          LRE_OP_LITRET, LRE_OP_RET, LRE_OP_IRQRET: begin
            next_state = LRE_ST_FLUSH;
            next_ready = 1'b0;
          end
          LRE_OP_NONE, LRE_OP_NOP, LRE_OP_LDLIT: begin
            next_state = LRE_ST_EXEC;
          end
        endcase
      end
      LRE_ST_FLUSH: begin
        next_state = LRE_ST_EXEC;
      end
    endcase
  end

  // Ready leaves reset high so the first word is taken at once
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= LRE_ST_EXEC;
      insn_ready <= 1'b1;
    end else begin
      state      <= next_state;
      insn_ready <= next_ready;
    end
  end

  // Accumulator: both literal ops load the low byte of the word
  always_comb begin
    next_acc = acc;
    unique case (exec_op)
      LRE_OP_LDLIT: begin
        next_acc = insn[LIT_LSB +: DATA_WIDTH];
      end
      LRE_OP_LITRET: begin
        next_acc = insn[LIT_LSB +: DATA_WIDTH];
      end
      LRE_OP_NONE, LRE_OP_NOP, LRE_OP_RET, LRE_OP_IRQRET: begin
        next_acc = acc;
      end
    endcase
  end

  // Accumulator register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= DATA_WIDTH'(ACC_RST);
    end else begin
      acc <= next_acc;
    end
  end

  // Program counter: returns take the stack top, no-op and load literal
  // step by one; any other word, or none taken, leaves it unchanged
  always_comb begin
    next_pc = pc;
    unique case (exec_op)
      LRE_OP_NOP, LRE_OP_LDLIT: begin
        next_pc = pc + PC_WIDTH'(CYC_ONE);
      end
      LRE_OP_LITRET: begin
        next_pc = stack_top;
      end
      LRE_OP_RET: begin
        next_pc = stack_top;
      end
      LRE_OP_IRQRET: begin
        next_pc = stack_top;
      end
      LRE_OP_NONE: begin
        next_pc = pc;
      end
    endcase
  end

  // Program counter register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= PC_WIDTH'(PC_RST);
    end else begin
      pc <= next_pc;
    end
  end

  // Interrupt control: the return's set comes last, so it wins over
  // a clear in the same cycle and no interrupt window is lost
  always_comb begin
    next_irq_ctrl = irq_ctrl;
    if (irq_en_clr) begin
      next_irq_ctrl[GIE_BIT] = 1'b0;
    end
    if (exec_op == LRE_OP_IRQRET) begin
      next_irq_ctrl[GIE_BIT] = 1'b1;
    end
  end

  // Only the enable bit moves; the rest keep their reset value
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ctrl <= ICR_RST;
    end else begin
      irq_ctrl <= next_irq_ctrl;
    end
  end

  // Pop strobe lasts one cycle; the stack owner shifts on it
  always_comb begin
    next_stack_pop = 1'b0;
    next_status_we = 1'b0;
    unique case (exec_op)
      LRE_OP_LITRET: begin
        next_stack_pop = 1'b1;
      end
      LRE_OP_RET: begin
        next_stack_pop = 1'b1;
      end
      LRE_OP_IRQRET: begin
        next_stack_pop = 1'b1;
      end
      LRE_OP_NONE, LRE_OP_NOP, LRE_OP_LDLIT: begin
        next_stack_pop = 1'b0;
      end
    endcase
  end

  // Status write enable is registered so the port cannot glitch
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_pop <= 1'b0;
      status_we <= 1'b0;
    end else begin
      stack_pop <= next_stack_pop;
      status_we <= next_status_we;
    end
  end
endmodule // lre_exec
`default_nettype wire

/* tb/lre_exec_props.sv */
// Port checker for the literal and return execution unit.
// Assumes it is bound onto lre_exec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lre_exec_props
  import lre_pkg::*;
(
  input wire logic        mclk, sys_rst, insn_valid, irq_en_clr, // Inputs
  input wire logic        stack_pop, insn_ready, status_we,  // Strobes
  input wire logic [13:0] insn,                              // Word
  input wire logic [12:0] stack_top, pc,                     // Addresses
  input wire logic [7:0]  acc, irq_ctrl                      // Registers
);
  // Taken word and return decode
  wire logic tk = insn_valid & insn_ready;
  wire logic rt = insn == OPC_RETURN | insn == OPC_IRQ_RET |
                  insn[13:10] == 4'hd;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_ldlit_acc: assert property (tk && insn[13:10] == 4'hc |=>
    acc == $past(insn[7:0])) else $error("load literal wrong");
  a_litret_both: assert property (tk && insn[13:10] == 4'hd |=>
    acc == $past(insn[7:0]) && pc == $past(stack_top)) else $error("retlit");
  a_ret_pc: assert property (tk && insn == OPC_RETURN |=>
    pc == $past(stack_top)) else $error("return pc wrong");
  a_irqret_gie: assert property (tk && insn == OPC_IRQ_RET |=>
    irq_ctrl[7] && pc == $past(stack_top)) else $error("irq return");
  a_ret_flush: assert property (tk && rt |=>
    stack_pop && !insn_ready ##1 !stack_pop && insn_ready) else $error("flush");
  a_nop_pc: assert property (tk && insn == OPC_NOP |=>
    pc == $past(pc) + 13'h1 && $stable(acc)) else $error("nop changed state");
  a_pop_cause: assert property (stack_pop |->
    $past(tk && rt)) else $error("pop without return");
  a_no_status: assert property (!status_we)
    else $error("status written");
endmodule // lre_exec_props
`default_nettype wire

/* tb/lre_exec_tb_top.sv */
// Random bench for lre_exec, checked against an inline model.
// Assumes lre_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lre_exec_tb_top
  import lre_pkg::*;
;
  logic mclk = 0, sys_rst = 1, insn_valid = 0, irq_en_clr = 0, tk;
  logic [13:0] insn = 0;
  logic [12:0] stack_top = 0, pc, e_pc = 0;
  logic [7:0] acc, irq_ctrl, e_acc = 0;
  logic stack_pop, insn_ready, status_we, e_gie = 0, e_rdy = 1, e_pop = 0;
  int seed = 32'h8bb3, n_errors = 0, samples_checked = 0;
  always #2 mclk = ~mclk;
  lre_exec dut (.mclk, .sys_rst, .insn, .insn_valid, .stack_top,
    .irq_en_clr, .acc, .pc, .irq_ctrl, .stack_pop, .insn_ready, .status_we);
  task chk(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t output differs", $time);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog well past the 2000-cycle run
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
  // First word: irq return with clear in the same cycle, set must win
  initial begin
    repeat (16) @(posedge mclk);
    #1 sys_rst = 0;
    for (int i = 0; i < 2000; i++) begin
      case (i == 0 ? 4 : $random(seed) & 7)
        0: insn = OPC_NOP;
        1: insn = {4'hc, 10'($random(seed))};
        2: insn = {4'hd, 10'($random(seed))};
        3: insn = OPC_RETURN;
        4: insn = OPC_IRQ_RET;
        default: insn = 14'($random(seed));
      endcase
      insn_valid = i == 0 || ($random(seed) & 3) != 0;
      irq_en_clr = i == 0 || ($random(seed) & 7) == 0;
      stack_top = 13'($random(seed));
      tk = insn_valid & e_rdy;
      e_pop = tk & (insn == OPC_RETURN | insn == OPC_IRQ_RET |
                    insn[13:10] == 4'hd);
      if (tk & (insn == OPC_NOP | insn[13:10] == 4'hc)) e_pc++;
      if (tk & insn[13:11] == 3'h6) e_acc = insn[7:0];
      if (e_pop) e_pc = stack_top;
      e_gie = tk & insn == OPC_IRQ_RET | e_gie & ~irq_en_clr;
      e_rdy = ~e_pop;
      @(posedge mclk);
      #1;
      chk(13'(acc), 13'(e_acc));
      chk(pc, e_pc);
      chk(13'(irq_ctrl), {5'h0, e_gie, 7'h0});
      chk({11'h0, stack_pop, insn_ready}, {11'h0, e_pop, e_rdy});
      chk(13'(status_we), 13'h0);
    end
    tally_and_finish;
  end
endmodule // lre_exec_tb_top
bind lre_exec lre_exec_props u_props (.mclk, .sys_rst, .insn_valid,
  .irq_en_clr, .stack_pop, .insn_ready, .status_we, .insn, .stack_top,
  .pc, .acc, .irq_ctrl);
`default_nettype wire
